// >>> verilog/mux_bus_word_codec.sv
`timescale 1ns/1ns
// Function
// - One is sent high half then low.
// - Zero is sent low half then high.
// - Every bit has a mid-bit transition.
// - Bit rate one megabit per second.
// - Word is sync, sixteen bits, parity.
// - Most significant information bit goes first.
// - Multiword quantities send most significant word first.
// - Unused bit positions are sent as zero.
// - Command sync: 1.5 high, 1.5 low.
// - Accept stretched sync low half before zero.
// - Command fields: address, direction, subaddress, count.
// - First five bits are terminal address.
// - Broadcast address also accepted when enabled.
// - Direction bit: zero receive, one transmit.
// - Next five bits: subaddress or mode.
// - Subaddress all-zeros/all-ones mean mode control.
// - Terminals transmit only when commanded.
// - Half duplex: never drive over another talker.
// - Receiver recovers timing from the signal.
// - Words classed as command, status, data.
// - Count zero means thirty-two words.
// - Odd parity over sixteen information bits.
// - Mode subaddress makes count a mode code.
module mux_bus_word_codec
  import mux_codec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_hi_i,
  input wire logic rx_lo_i,
  output logic tx_hi_o,
  output logic tx_lo_o,
  output logic tx_en_o
);

  function automatic logic [TX_HALVES-1:0] build_pattern(input logic [INFO_BITS-1:0] w, input logic cmd);
    logic [TX_HALVES-1:0] p;
    logic [WORD_BITS-1:0] bits;
    p = '0;
    bits = {w, ~^w};
    p[SYNC_HALVES-1:0] = cmd ? SYNC_CMD_PAT : SYNC_DATA_PAT;
    for (int i = WORD_BITS - 1; i >= 0; i--)
    begin
      // Each bit as two halves, true value first, so ones are 1/0 and zeros 0/1
      p = {p[TX_HALVES-3:0], bits[i], ~bits[i]};
    end
    return p;
  endfunction

  logic ack_r;
  logic [31:0] dat_r;
  logic req, wr, rd;
  ctrl_t ctrl_r;
  status_t st_r;
  logic [INFO_BITS-1:0] rx_word_r;
  fields_rd_t fields_r;
  logic [1:0] hi_sync_r, lo_sync_r, lvl, lvl_d_r;
  logic chg;
  logic [CNT_W-1:0] run_r;
  rx_state_t rx_state_r;
  logic sync_pos_r, first_r, bad_r;
  logic [CNT_W-1:0] cnt_r;
  logic [4:0] nbit_r;
  logic [WORD_BITS-1:0] shift_r, new_shift;
  logic lvl_ok, early, late, bit_bad, word_done, word_good, sync_seen;
  cmd_fields_t rx_f;
  logic rx_match, rx_individual, rx_mode;
  word_kind_t rx_kind;
  logic [TX_HALVES-1:0] pat_r;
  logic [CNT_W-1:0] half_r;
  logic [5:0] idx_r;
  logic tx_hi_r, tx_lo_r, tx_en_r;
  tx_req_t tx_req;
  logic tx_allowed, tx_start, tx_end;
  status_t w1c;
  ctrl_t ctrl_wr;

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign tx_hi_o = tx_hi_r;
  assign tx_lo_o = tx_lo_r;
  assign tx_en_o = tx_en_r;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign w1c = status_t'(wb_dat_i[$bits(status_t)-1:0]);
  assign ctrl_wr = ctrl_t'(wb_dat_i[$bits(ctrl_t)-1:0]);
  assign tx_req = tx_req_t'(wb_dat_i[$bits(tx_req_t)-1:0]);

  // Two flops on each receiver comparator before any logic looks at them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_sync_r <= '0;
      lo_sync_r <= '0;
      lvl_d_r <= '0;
    end
    else
    begin
      hi_sync_r <= {hi_sync_r[0], rx_hi_i};
      lo_sync_r <= {lo_sync_r[0], rx_lo_i};
      lvl_d_r <= lvl;
    end
  end

  assign lvl = {hi_sync_r[1], lo_sync_r[1]};
  assign chg = lvl != lvl_d_r;
  assign lvl_ok = (lvl == LVL_HI) || (lvl == LVL_LO);

  // Length of the current line level, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i || chg)
      run_r <= '0;
    else if (run_r != RUN_SAT)
      run_r <= run_r + 1'b1;
  end

  // A sync half is a level run of 1.5 bit times, which no valid bit code can produce
  assign sync_seen = chg && (lvl == ~lvl_d_r) && lvl_ok && (run_r >= SYNC_MIN) && (run_r <= SYNC_MAX);

  assign early = cnt_r == QTR_CYC;
  assign late = cnt_r == BIT_CYC - QTR_CYC;
  assign bit_bad = !lvl_ok || ((lvl == LVL_HI) == first_r);
  assign new_shift = {shift_r[WORD_BITS-2:0], first_r};
  assign word_done = (rx_state_r == RX_BITS) && late && (nbit_r == 5'(WORD_BITS - 1));
  assign word_good = word_done && !bad_r && !bit_bad && (^new_shift);

  assign rx_f = cmd_fields_t'(new_shift[WORD_BITS-1:1]);
  assign rx_individual = rx_f.addr == ctrl_r.own_addr;
  assign rx_match = rx_individual || (ctrl_r.bcast_en && (rx_f.addr == BCAST_ADDR));
  assign rx_mode = (rx_f.sub == SUB_MODE_LO) || (rx_f.sub == SUB_MODE_HI);
  // Positive-first sync is command or status; which one depends on our role
  assign rx_kind = !sync_pos_r ? KIND_DATA : (ctrl_r.role_bc ? KIND_STATUS : KIND_CMD);

  // Receiver: locks to the sync, then re-centres on every mid-bit transition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_state_r <= RX_IDLE;
      sync_pos_r <= 1'b0;
      cnt_r <= '0;
      nbit_r <= '0;
      first_r <= 1'b0;
      bad_r <= 1'b0;
      shift_r <= '0;
    end
    else
    begin
      case (rx_state_r)
        RX_IDLE:
        begin
          if (sync_seen)
          begin
            rx_state_r <= RX_SYNC;
            sync_pos_r <= lvl_d_r == LVL_HI;
            cnt_r <= '0;
          end
        end
        RX_SYNC:
        begin
          // Only the first part of the second half is checked, so a half that runs on into a zero bit still passes
          if ((cnt_r < SYNC_MIN) && (lvl != lvl_d_r || !lvl_ok))
            rx_state_r <= RX_IDLE;
          else if (cnt_r == SYNC_HALF_CYC - 1'b1)
          begin
            rx_state_r <= RX_BITS;
            cnt_r <= '0;
            nbit_r <= '0;
            bad_r <= 1'b0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        RX_BITS:
        begin
          // Bit timing comes from the line itself; our clock only measures between transitions
          if (chg && (cnt_r > QTR_CYC) && (cnt_r < BIT_CYC - QTR_CYC))
            cnt_r <= HALF_CYC;
          else if (cnt_r == BIT_CYC - 1'b1)
            cnt_r <= '0;
          else
            cnt_r <= cnt_r + 1'b1;
          if (early)
          begin
            first_r <= lvl == LVL_HI;
            if (!lvl_ok)
              bad_r <= 1'b1;
          end
          if (late)
          begin
            shift_r <= new_shift;
            nbit_r <= nbit_r + 1'b1;
            if (bit_bad)
              bad_r <= 1'b1;
            if (word_done)
              rx_state_r <= RX_IDLE;
          end
        end
        default:
          rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Received word and decoded command fields; invalid words never reach these
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_word_r <= '0;
      fields_r <= '0;
    end
    else if (word_good)
    begin
      rx_word_r <= new_shift[WORD_BITS-1:1];
      fields_r.f <= rx_f;
      fields_r.mode <= rx_mode;
      fields_r.count <= (rx_f.cnt == CNT_ZERO) ? MAX_COUNT : {1'b0, rx_f.cnt};
    end
  end

  // Transmission is refused while the line is busy, and for a terminal until it is commanded
  assign tx_allowed = !st_r.tx_busy && (rx_state_r == RX_IDLE) && (lvl == '0)
                      && (ctrl_r.role_bc || st_r.resp_ok);
  assign tx_start = wr && (wb_adr_i == REG_TX_WORD) && tx_allowed;
  assign tx_end = st_r.tx_busy && (half_r == HALF_CYC - 1'b1) && (idx_r == 6'(TX_HALVES - 1));

  // Status flags: hardware set wins over a same-cycle software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
    begin
      if (tx_start)
        st_r.tx_busy <= 1'b1;
      else if (tx_end)
        st_r.tx_busy <= 1'b0;
      if (word_good)
        st_r.rx_valid <= 1'b1;
      else if ((wr && wb_adr_i == REG_STATUS && w1c.rx_valid) || (rd && wb_adr_i == REG_RX_WORD))
        st_r.rx_valid <= 1'b0;
      if (word_done && !word_good)
        st_r.rx_err <= 1'b1;
      else if (wr && wb_adr_i == REG_STATUS && w1c.rx_err)
        st_r.rx_err <= 1'b0;
      if (word_good)
      begin
        st_r.kind <= rx_kind;
        st_r.addressed <= (rx_kind == KIND_CMD) && rx_match;
        st_r.bcast <= (rx_kind == KIND_CMD) && rx_match && !rx_individual;
      end
      // A command to our own address permits transmitting, not cleared by a transmit; any new sync withdraws it
      if (word_good && rx_kind == KIND_CMD && rx_individual)
        st_r.resp_ok <= 1'b1;
      else if (sync_seen)
        st_r.resp_ok <= 1'b0;
      if (wr && wb_adr_i == REG_TX_WORD && !tx_allowed)
        st_r.tx_refused <= 1'b1;
      else if (wr && wb_adr_i == REG_STATUS && w1c.tx_refused)
        st_r.tx_refused <= 1'b0;
    end
  end

  // Control register; an attempt to take the shared address as our own is ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= CTRL_RST;
    else if (wr && wb_adr_i == REG_CTRL)
    begin
      ctrl_r.role_bc <= ctrl_wr.role_bc;
      ctrl_r.bcast_en <= ctrl_wr.bcast_en;
      if (ctrl_wr.own_addr != BCAST_ADDR)
        ctrl_r.own_addr <= ctrl_wr.own_addr;
    end
  end

  // Transmitter: one half-bit per HALF_CYC clocks, 40 halves per word.
  // Words go out in write order, so software writes the most significant word first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pat_r <= '0;
      half_r <= '0;
      idx_r <= '0;
      tx_hi_r <= 1'b0;
      tx_lo_r <= 1'b0;
      tx_en_r <= 1'b0;
    end
    else if (tx_start)
    begin
      // The whole information field comes from software, so unused bits leave as written zeros
      pat_r <= build_pattern(tx_req.word, tx_req.cmd_sync);
      half_r <= '0;
      idx_r <= '0;
      tx_en_r <= 1'b1;
      tx_hi_r <= tx_req.cmd_sync;
      tx_lo_r <= !tx_req.cmd_sync;
    end
    else if (st_r.tx_busy)
    begin
      if (half_r == HALF_CYC - 1'b1)
      begin
        half_r <= '0;
        if (tx_end)
        begin
          tx_en_r <= 1'b0;
          tx_hi_r <= 1'b0;
          tx_lo_r <= 1'b0;
        end
        else
        begin
          idx_r <= idx_r + 1'b1;
          pat_r <= {pat_r[TX_HALVES-2:0], 1'b0};
          tx_hi_r <= pat_r[TX_HALVES-2];
          tx_lo_r <= !pat_r[TX_HALVES-2];
        end
      end
      else
        half_r <= half_r + 1'b1;
    end
  end

  // Wishbone slave: ack one clock after the request, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end
    else
    begin
      ack_r <= req;
      if (rd)
      begin
        case (wb_adr_i)
          REG_CTRL: dat_r <= 32'(ctrl_r);
          REG_STATUS: dat_r <= 32'(st_r);
          REG_RX_WORD: dat_r <= 32'(rx_word_r);
          REG_RX_FIELDS: dat_r <= 32'(fields_r);
          default: dat_r <= '0;
        endcase
      end
    end
  end

endmodule // mux_bus_word_codec

// >>> verilog/mux_codec_pkg.sv
package mux_codec_pkg;

  // Bus clock and line timing
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 1000;
  localparam int CNT_W = 8;
  localparam int BIT_CYC_I = BIT_NS / CLK_NS;
  localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(BIT_CYC_I);
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_CYC_I / 2);
  localparam logic [CNT_W-1:0] QTR_CYC = CNT_W'(BIT_CYC_I / 4);
  localparam logic [CNT_W-1:0] SYNC_HALF_CYC = CNT_W'(BIT_CYC_I * 3 / 2);
  localparam logic [CNT_W-1:0] SYNC_MIN = CNT_W'(BIT_CYC_I * 3 / 2 - BIT_CYC_I / 4);
  localparam logic [CNT_W-1:0] SYNC_MAX = CNT_W'(BIT_CYC_I * 3 / 2 + BIT_CYC_I / 4);
  localparam logic [CNT_W-1:0] RUN_SAT = {CNT_W{1'b1}};

  // Word layout
  localparam int INFO_BITS = 16;
  localparam int WORD_BITS = INFO_BITS + 1;
  localparam int SYNC_HALVES = 6;
  localparam int TX_HALVES = 2 * WORD_BITS + SYNC_HALVES;
  localparam logic [SYNC_HALVES-1:0] SYNC_CMD_PAT = 6'h38;
  localparam logic [SYNC_HALVES-1:0] SYNC_DATA_PAT = 6'h07;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 5'h1f;
  localparam logic [4:0] SUB_MODE_LO = 5'h00;
  localparam logic [4:0] SUB_MODE_HI = 5'h1f;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [5:0] MAX_COUNT = 6'h20;

  // Line levels seen as {hi, lo}
  localparam logic [1:0] LVL_HI = 2'h2;
  localparam logic [1:0] LVL_LO = 2'h1;

  // Register map (byte addresses)
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_RX_WORD = 8'h08;
  localparam logic [ADR_W-1:0] REG_RX_FIELDS = 8'h0c;
  localparam logic [ADR_W-1:0] REG_TX_WORD = 8'h10;

  typedef enum logic [1:0] {KIND_NONE, KIND_CMD, KIND_STATUS, KIND_DATA} word_kind_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS} rx_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic tr;
    logic [4:0] sub;
    logic [4:0] cnt;
  } cmd_fields_t;

  typedef struct packed {
    logic role_bc;
    logic bcast_en;
    logic [ADDR_W-1:0] own_addr;
  } ctrl_t;

  typedef struct packed {
    logic tx_refused;
    logic resp_ok;
    logic bcast;
    logic addressed;
    word_kind_t kind;
    logic rx_err;
    logic rx_valid;
    logic tx_busy;
  } status_t;

  typedef struct packed {
    logic [5:0] count;
    logic mode;
    cmd_fields_t f;
  } fields_rd_t;

  typedef struct packed {
    logic cmd_sync;
    logic [INFO_BITS-1:0] word;
  } tx_req_t;

  localparam ctrl_t CTRL_RST = '0;

endpackage

// >>> dv/mux_codec_chk.sv
`timescale 1ns/1ns
module mux_codec_chk
  import mux_codec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_hi_i,
  input wire logic rx_lo_i,
  input wire logic tx_hi_o,
  input wire logic tx_lo_o,
  input wire logic tx_en_o
);
  logic [10:0] hcnt_r;
  logic wr_tx_r;
  // Cycles since the line was taken; zero while idle
  always_ff @(posedge clk_i)
    if (rst_i || !tx_en_o)
      hcnt_r <= 11'h000;
    else
      hcnt_r <= hcnt_r + 11'h001;
  always_ff @(posedge clk_i)
    wr_tx_r <= !rst_i && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == REG_TX_WORD;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  a_lo_inverse: assert property (tx_en_o |-> tx_lo_o == !tx_hi_o)
    else $error("line halves not complementary");
  a_idle_quiet: assert property (!tx_en_o |-> !tx_hi_o && !tx_lo_o)
    else $error("line driven while not enabled");
  a_half_grid: assert property (tx_en_o && hcnt_r != 0 && $changed(tx_hi_o) |-> hcnt_r % 50 == 0)
    else $error("line level changed off the half-bit grid");
  a_mid_flip: assert property (tx_en_o && hcnt_r >= 300 && hcnt_r % 100 == 50 |-> $changed(tx_hi_o))
    else $error("bit without mid-bit transition");
  a_word_len: assert property ($fell(tx_en_o) && !$past(rst_i) |-> $past(hcnt_r) == 1999)
    else $error("word not twenty bit times long");
  a_sync_shape: assert property ($rose(tx_en_o) |-> ##149 tx_hi_o == $past(tx_hi_o, 149)
    ##1 tx_hi_o != $past(tx_hi_o, 150))
    else $error("sync not one and a half bits per level");
  a_quiet_start: assert property ($rose(tx_en_o) |-> !$past(rx_hi_i, 3) && !$past(rx_lo_i, 3))
    else $error("transmit started over a busy line");
  a_cmd_only: assert property ($rose(tx_en_o) |-> wr_tx_r)
    else $error("transmit started without a word write");
endmodule // mux_codec_chk

bind mux_bus_word_codec mux_codec_chk i_mux_codec_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_hi_i(rx_hi_i), .rx_lo_i(rx_lo_i), .tx_hi_o(tx_hi_o), .tx_lo_o(tx_lo_o), .tx_en_o(tx_en_o));

// >>> dv/line_partner.sv
`timescale 1ns/1ns
module line_partner (
  input wire logic tx_hi_i,
  input wire logic tx_en_i,
  output logic line_hi_o,
  output logic line_lo_o
);
  logic [39:0] cap;
  int ncap;
  initial
  begin
    line_hi_o = 1'b0;
    line_lo_o = 1'b0;
    ncap = 0;
  end
  // Own time base with an odd offset, so the block must recover timing
  task automatic send(input logic [39:0] h);
    #3;
    for (int i = 39; i >= 0; i--)
    begin
      line_hi_o = h[i];
      line_lo_o = !h[i];
      #500;
    end
    line_hi_o = 1'b0;
    line_lo_o = 1'b0;
  endtask
  // Sample each half-bit at its middle
  always @(posedge tx_en_i)
  begin
    #250;
    for (int i = 39; i >= 0; i--)
    begin
      cap[i] = tx_hi_i;
      if (i > 0)
        #500;
    end
    ncap++;
  end
endmodule // line_partner

// >>> dv/test_mux_bus_word_codec.sv
`timescale 1ns/1ns
module test_mux_bus_word_codec
  import mux_codec_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_hi_i, rx_lo_i, tx_hi_o, tx_lo_o, tx_en_o;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int n;
  always #5 clk_i = !clk_i;
  mux_bus_word_codec i_mux_bus_word_codec (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_hi_i(rx_hi_i), .rx_lo_i(rx_lo_i), .tx_hi_o(tx_hi_o),
    .tx_lo_o(tx_lo_o), .tx_en_o(tx_en_o));
  line_partner i_line_partner (.tx_hi_i(tx_hi_o), .tx_en_i(tx_en_o), .line_hi_o(rx_hi_i), .line_lo_o(rx_lo_i));
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // Sync, sixteen bits MSB first as {b, !b}, odd parity
  function automatic logic [39:0] enc(input logic c, input logic [15:0] w);
    logic [39:0] h;
    h[39:34] = c ? 6'h38 : 6'h07;
    for (int i = 0; i < 16; i++)
      h[2*i+3 -: 2] = {w[i], !w[i]};
    h[1:0] = {~^w, ^w};
    return h;
  endfunction
  function automatic logic [31:0] fld(input logic [15:0] w);
    return {9'h0, (w[4:0] == 5'h00) ? 6'h20 : {1'b0, w[4:0]}, (w[9:5] == 5'h00 || w[9:5] == 5'h1f), w};
  endfunction
  task automatic rx_case(input logic [39:0] h, input logic [31:0] m, input logic [31:0] st,
    input logic [15:0] w, input logic [31:0] f);
    i_line_partner.send(h);
    q = 32'h0;
    for (int i = 0; i < 20 && q[2:1] == 2'b00; i++)
      rd(REG_STATUS);
    chk("status", 40'(st & m), 40'(q & m));
    rd(REG_RX_WORD);
    chk("rx word", 40'(w), 40'(q));
    rd(REG_RX_FIELDS);
    chk("rx fields", 40'(f), 40'(q));
    wb(1'b1, REG_STATUS, 32'h106);
  endtask
  task automatic wait_tx(input int n0);
    for (int i = 0; i < 700 && (q[0] !== 1'b0 || i_line_partner.ncap == n0); i++)
      rd(REG_STATUS);
  endtask
  task automatic t_regs;
    rd(REG_CTRL);
    chk("ctrl reset", 40'h0, 40'(q));
    rd(REG_STATUS);
    chk("status reset", 40'h0, 40'(q));
    wb(1'b1, REG_CTRL, 32'h25);
    wb(1'b1, REG_CTRL, 32'h7f);
    rd(REG_CTRL);
    chk("ctrl own kept", 40'h65, 40'(q));
    wb_sel_i <= 4'he;
    wb(1'b1, REG_CTRL, 32'h0);
    wb_sel_i <= 4'hf;
    rd(REG_CTRL);
    chk("ctrl sel ignored", 40'h65, 40'(q));
    wb(1'b1, REG_CTRL, 32'h25);
    rd(8'h14);
    chk("unmapped", 40'h0, 40'(q));
    $display("registers done");
  endtask
  task automatic t_rx;
    rx_case(enc(1'b1, 16'h2c40), 32'hfe, 32'haa, 16'h2c40, fld(16'h2c40));
    rx_case(enc(1'b1, 16'hffe2), 32'hfe, 32'h6a, 16'hffe2, fld(16'hffe2));
    rx_case(enc(1'b1, 16'h303f), 32'hfe, 32'h0a, 16'h303f, fld(16'h303f));
    rx_case(enc(1'b0, 16'h8001), 32'h1e, 32'h1a, 16'h8001, fld(16'h8001));
    $display("receive done");
  endtask
  task automatic t_bad;
    rx_case(enc(1'b0, 16'hffff) ^ 40'h3, 32'h06, 32'h04, 16'h8001, fld(16'h8001));
    rx_case(enc(1'b0, 16'hffff) | 40'h3, 32'h06, 32'h04, 16'h8001, fld(16'h8001));
    wb(1'b1, REG_TX_WORD, 32'h1a5c3);
    rd(REG_STATUS);
    chk("tx refused", 40'h100, 40'(q & 32'h101));
    wb(1'b1, REG_STATUS, 32'h106);
    $display("faults done");
  endtask
  task automatic t_tx;
    rx_case(enc(1'b1, 16'h2c40), 32'hfe, 32'haa, 16'h2c40, fld(16'h2c40));
    n = i_line_partner.ncap;
    wb(1'b1, REG_TX_WORD, 32'h1a5c3);
    rd(REG_STATUS);
    chk("tx busy", 40'h3, 40'({q[0], tx_en_o}));
    wait_tx(n);
    chk("cmd halves", enc(1'b1, 16'ha5c3), i_line_partner.cap);
    wb(1'b1, REG_CTRL, 32'h65);
    n = i_line_partner.ncap;
    wb(1'b1, REG_TX_WORD, 32'h00001);
    rd(REG_STATUS);
    wait_tx(n);
    chk("data halves", enc(1'b0, 16'h0001), i_line_partner.cap);
    rx_case(enc(1'b1, 16'h2800), 32'h1e, 32'h12, 16'h2800, fld(16'h2800));
    $display("transmit done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_rx;
    t_bad;
    t_tx;
    report_and_stop;
  end
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 40000)
    begin
      errors++;
      $display("Error run length expected below 40000 seen 40000");
      report_and_stop;
    end
  end
endmodule // test_mux_bus_word_codec
